// file: scan_pkg.sv
package scan_pkg;

	// ************************************************************
	// sizes and fixed capture values
	// ************************************************************
	localparam int IR_W = 3;
	localparam int BSR_W = 132;
	localparam logic [IR_W-1:0] IR_RESET = 3'h7;
	localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
	localparam int IR_LOSS_BIT = 2;
	localparam logic [7:0] NO_CTL = 8'hFF;

	// ************************************************************
	// instruction codes
	// ************************************************************
	localparam logic [IR_W-1:0] CODE_EXTEST = 3'h0;
	localparam logic [IR_W-1:0] CODE_SAMPLE = 3'h1;
	localparam logic [IR_W-1:0] CODE_ALL_OFF = 3'h4;
	localparam logic [IR_W-1:0] CODE_BYPASS_ALT = 3'h5;
	localparam int CODE_BYPASS_BIT = 1;

	// ************************************************************
	// control cell positions in the boundary chain
	// ************************************************************
	localparam logic [7:0] ADDRESS_BUS_DRIVE_CTL = 8'h53;
	localparam logic [7:0] BERR_CTL = 8'h54;
	localparam logic [7:0] DATA_BUS_DRIVE_CTL = 8'h55;

	typedef enum logic [1:0] {i_extest, i_sample, i_bypass, i_all_off} instr_e;

	typedef enum logic [3:0] {
		tlr, rti, sel_dr, cap_dr, sh_dr, ex1_dr, pa_dr, ex2_dr, up_dr,
		sel_ir, cap_ir, sh_ir, ex1_ir, pa_ir, ex2_ir, up_ir
	} tap_state_e;

	// only four instructions exist; every other code falls to bypass
	function automatic instr_e decode_instr(input logic [IR_W-1:0] code);
		if (code[CODE_BYPASS_BIT] || code == CODE_BYPASS_ALT)
			return i_bypass;
		else if (code == CODE_EXTEST)
			return i_extest;
		else if (code == CODE_SAMPLE)
			return i_sample;
		else
			return i_all_off;
	endfunction : decode_instr

	// index of the cell that steers the driver of cell i
	function automatic logic [7:0] ctl_of(input int i);
		if ((i >= 0 && i <= 26) || i == 102 || (i >= 105 && i <= 110))
			return ADDRESS_BUS_DRIVE_CTL;
		else if (i >= 67 && i <= 82)
			return DATA_BUS_DRIVE_CTL;
		else if (i == 103 || i == 104 || i == 114)
			return BERR_CTL;
		else if (i == 28 || (i >= 51 && i <= 65 && i % 2 == 1) ||
			(i >= 86 && i <= 100 && i % 2 == 0) || i == 121 || i == 124 || i == 129)
			return 8'(i + 1);
		else
			return NO_CTL;
	endfunction : ctl_of

	// active_high_ctl_cell positions; all other control cells are active_low_ctl_cell
	function automatic logic ctl_active_high(input logic [7:0] c);
		return c == ADDRESS_BUS_DRIVE_CTL || c == DATA_BUS_DRIVE_CTL;
	endfunction : ctl_active_high

	// cells that never drive a pin: inputs and control cells
	function automatic logic no_driver(input int i);
		case (i)
			27, 29, 30, 31, 34, 37, 40, 41, 42, 43, 46, 47, 50, 83, 84, 85,
			111, 113, 116, 118, 120, 122, 125, 126, 128, 130, 131: return 1'b1;
			default: return (i >= 52 && i <= 66 && i % 2 == 0) ||
				(i >= 87 && i <= 101 && i % 2 == 1);
		endcase
	endfunction : no_driver

	// open-drain output latches drive low only
	function automatic logic open_drain(input int i);
		return i == 45 || i == 49 || i == 115 || i == 117;
	endfunction : open_drain

endpackage : scan_pkg

// file: boundary_chain.sv
`timescale 1ns/1ps
module boundary_chain
	import scan_pkg::*;
(
	input wire logic tck,
	input wire logic tap_rst_b,
	input wire logic capture,
	input wire logic shift,
	input wire logic update,
	input wire logic tdi,
	input wire logic [BSR_W-1:0] cap_data,
	output logic so,
	output logic [BSR_W-1:0] upd
);

	// ************************************************************
	// shift stage: bit 0 sits next to the serial output
	// ************************************************************
	logic [BSR_W-1:0] sh;

	always_ff @(posedge tck)
	begin
		if (!tap_rst_b)
			sh <= '0;
		else if (capture)
			sh <= cap_data;
		else if (shift)
			sh <= {tdi, sh[BSR_W-1:1]};
	end

	// ************************************************************
	// parallel stage: holds pins steady while the chain shifts
	// ************************************************************
	always_ff @(posedge tck)
	begin
		if (!tap_rst_b)
			upd <= '0;
		else if (update)
			upd <= sh;
	end

	assign so = sh[0];

endmodule : boundary_chain

// file: scan_instr_logic.sv
`timescale 1ns/1ps
// How it works
// - three-bit instruction register, shift stage feeding three parallel output latches, no parity.
// - parallel instruction bits load from the shift stage only in update-IR.
// - test-logic-reset forces the parallel instruction to all ones, meaning bypass.
// - code 000 selects the external test instruction.
// - 001 sample/preload, x1x or 101 bypass, 100 all outputs off.
// - only the three mandatory instructions plus the all-outputs-off instruction exist.
// - all outputs off instruction turns every pin driver off.
// - all outputs off instruction puts the one-bit bypass register on the serial path.
// - capture-IR loads 01 in the low bits and crystal_loss_flag in bit 2.
// - capture-IR touches only the shift stage, never the parallel bits.
// - with a crystal, crystal_loss_flag is 0 with clock seen, 1 without.
// - in external clock mode crystal_loss_flag always reads zero.
// - external test puts the 132-bit boundary register between serial input and output.
// - external test holds the system logic in reset.
// - external test drives outputs, captures inputs, sets directions and three-state enables.
// - several bidirectional cells may share one output control cell.
// - active-high control cells enable on one, active-low ones on zero.
module scan_instr_logic
	import scan_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_b,
	input wire logic no_clock_seen,
	input wire logic ext_clock_mode,
	output logic sys_reset_b,
	input wire logic [BSR_W-1:0] core_out,
	input wire logic [BSR_W-1:0] core_oe_b,
	input wire logic [BSR_W-1:0] pin_in,
	output logic [BSR_W-1:0] pad_out,
	output logic [BSR_W-1:0] pad_oe_b
);

	// ************************************************************
	// system clock side: crystal loss status
	// ************************************************************
	logic nclk_s1;
	logic nclk_s2;
	logic mode_s1;
	logic mode_s2;
	logic crystal_loss_flag;

	always_ff @(posedge clk)
	begin
		nclk_s1 <= no_clock_seen;
		nclk_s2 <= nclk_s1;
		mode_s1 <= ext_clock_mode;
		mode_s2 <= mode_s1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			crystal_loss_flag <= 1'b0;
		else if (mode_s2)
			crystal_loss_flag <= 1'b0;
		else
			crystal_loss_flag <= nclk_s2;
	end

	// ************************************************************
	// test clock side: reset and state machine
	// ************************************************************
	logic trst_s1;
	logic tap_rst_b;
	tap_state_e state;
	tap_state_e next_state;

	// power-on reset reaches the test logic too, so pins cannot contend at power up
	always_ff @(posedge tck)
	begin
		trst_s1 <= rst_b;
		tap_rst_b <= trst_s1;
	end

	always_comb
	begin
		next_state = state;
		case (state)
			tlr: next_state = tms ? tlr : rti;
			rti: next_state = tms ? sel_dr : rti;
			sel_dr: next_state = tms ? sel_ir : cap_dr;
			cap_dr: next_state = tms ? ex1_dr : sh_dr;
			sh_dr: next_state = tms ? ex1_dr : sh_dr;
			ex1_dr: next_state = tms ? up_dr : pa_dr;
			pa_dr: next_state = tms ? ex2_dr : pa_dr;
			ex2_dr: next_state = tms ? up_dr : sh_dr;
			up_dr: next_state = tms ? sel_dr : rti;
			sel_ir: next_state = tms ? tlr : cap_ir;
			cap_ir: next_state = tms ? ex1_ir : sh_ir;
			sh_ir: next_state = tms ? ex1_ir : sh_ir;
			ex1_ir: next_state = tms ? up_ir : pa_ir;
			pa_ir: next_state = tms ? ex2_ir : pa_ir;
			ex2_ir: next_state = tms ? up_ir : sh_ir;
			up_ir: next_state = tms ? sel_dr : rti;
			default: next_state = tlr;
		endcase
	end

	always_ff @(posedge tck)
	begin
		if (!tap_rst_b)
			state <= tlr;
		else
			state <= next_state;
	end

	// ************************************************************
	// crystal loss status into the test clock domain
	// ************************************************************
	logic loss_t1;
	logic loss_t2;

	always_ff @(posedge tck)
	begin
		loss_t1 <= crystal_loss_flag;
		loss_t2 <= loss_t1;
	end

	// ************************************************************
	// instruction register
	// ************************************************************
	logic [IR_W-1:0] ir_sh;
	logic [IR_W-1:0] ir_par;
	instr_e instr;

	always_ff @(posedge tck)
	begin
		if (!tap_rst_b)
			ir_sh <= IR_RESET;
		else if (state == cap_ir)
			ir_sh <= {loss_t2, IR_CAPTURE_LOW};
		else if (state == sh_ir)
			ir_sh <= {tdi, ir_sh[IR_W-1:1]};
	end

	// capture and shift leave this stage alone, so pins stay put during an IR scan
	always_ff @(posedge tck)
	begin
		if (!tap_rst_b || state == tlr)
			ir_par <= IR_RESET;
		else if (state == up_ir)
			ir_par <= ir_sh;
	end

	// all-outputs-off is the only optional instruction decoded; unused codes are bypass
	assign instr = decode_instr(ir_par);

	// ************************************************************
	// data registers
	// ************************************************************
	logic bsr_sel;
	logic bypass_bit;
	logic bsr_so;
	logic [BSR_W-1:0] pin_s1;
	logic [BSR_W-1:0] pin_s2;
	logic [BSR_W-1:0] bsr_upd;

	assign bsr_sel = instr == i_extest || instr == i_sample;

	// pins are asynchronous to the test clock; capture reads the settled copy
	always_ff @(posedge tck)
	begin
		pin_s1 <= pin_in;
		pin_s2 <= pin_s1;
	end

	always_ff @(posedge tck)
	begin
		if (!tap_rst_b)
			bypass_bit <= 1'b0;
		else if (state == cap_dr)
			bypass_bit <= 1'b0;
		else if (state == sh_dr)
			bypass_bit <= tdi;
	end

	boundary_chain u_chain (
		.tck(tck),
		.tap_rst_b(tap_rst_b),
		.capture(bsr_sel && state == cap_dr),
		.shift(bsr_sel && state == sh_dr),
		.update(bsr_sel && state == up_dr),
		.tdi(tdi),
		.cap_data(pin_s2),
		.so(bsr_so),
		.upd(bsr_upd)
	);

	// ************************************************************
	// serial output, changed on the falling test clock edge
	// ************************************************************
	always_ff @(negedge tck)
	begin
		if (!tap_rst_b)
		begin
			tdo <= 1'b0;
			tdo_oe_b <= 1'b1;
		end
		else
		begin
			tdo_oe_b <= !(state == sh_ir || state == sh_dr);
			if (state == sh_ir)
				tdo <= ir_sh[0];
			else if (bsr_sel)
				tdo <= bsr_so;
			else
				tdo <= bypass_bit;
		end
	end

	// ************************************************************
	// system reset while external test is selected
	// ************************************************************
	logic ext_tck;
	logic ext_c1;
	logic ext_c2;

	// moves on the same edge as the instruction latch, so a parked tck still releases it
	always_ff @(posedge tck)
	begin
		if (!tap_rst_b || state == tlr)
			ext_tck <= 1'b0;
		else if (state == up_ir)
			ext_tck <= decode_instr(ir_sh) == i_extest;
	end

	always_ff @(posedge clk)
	begin
		ext_c1 <= ext_tck;
		ext_c2 <= ext_c1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			sys_reset_b <= 1'b0;
		else
			sys_reset_b <= !ext_c2;
	end

	// ************************************************************
	// pad multiplexing
	// ************************************************************
	// boundary values reach pins without resynchronising; the test environment owns timing
	always_comb
	begin
		logic [7:0] c;
		logic en;
		c = NO_CTL;
		en = 1'b0;
		pad_out = core_out;
		pad_oe_b = core_oe_b;
		for (int i = 0; i < BSR_W; i++)
		begin
			c = ctl_of(i);
			if (instr == i_all_off)
			begin
				pad_oe_b[i] = 1'b1;
			end
			else if (instr == i_extest)
			begin
				pad_out[i] = bsr_upd[i];
				if (no_driver(i))
					en = 1'b0;
				else if (open_drain(i))
					en = !bsr_upd[i];
				else if (c == NO_CTL)
					en = 1'b1;
				else if (ctl_active_high(c))
					en = bsr_upd[c];
				else
					en = !bsr_upd[c];
				pad_oe_b[i] = !en;
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	tlr_all_ones_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		state == tlr |=> ir_par == IR_RESET && instr == i_bypass)
		else $error("instruction not bypass after test-logic-reset");

	capture_ir_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		state == cap_ir |=> ir_sh == {$past(loss_t2), IR_CAPTURE_LOW})
		else $error("capture-IR loaded wrong value");

	par_hold_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		state != up_ir && state != tlr |=> $stable(ir_par))
		else $error("parallel instruction changed outside update-IR");

	ir_update_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		state == up_ir |=> ir_par == $past(ir_sh))
		else $error("update-IR did not load shift stage");

	five_ones_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		tms [*5] |=> state == tlr)
		else $error("five mode-select ones did not reach reset");

	outputs_off_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		instr == i_all_off |-> &pad_oe_b)
		else $error("a driver is on under all outputs off");

	off_bypass_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		instr == i_all_off && state == cap_dr ##1 state == sh_dr |-> bypass_bit == 1'b0)
		else $error("bypass bit not cleared at capture");

	ctl_polarity_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		instr == i_extest |-> pad_oe_b[0] == !bsr_upd[ADDRESS_BUS_DRIVE_CTL] &&
			pad_oe_b[103] == bsr_upd[BERR_CTL])
		else $error("control cell polarity wrong");

	ext_reset_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		ext_c1 [*2] |=> !sys_reset_b)
		else $error("system not held in reset under external test");

	ext_clock_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		mode_s2 |=> !crystal_loss_flag)
		else $error("loss flag set in external clock mode");

	tdo_drive_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		state == sh_ir || state == sh_dr |-> !tdo_oe_b)
		else $error("serial output not driven while shifting");

	bsr_path_a: assert property (
		@(posedge tck) disable iff (!tap_rst_b)
		bsr_sel && state == sh_dr |-> tdo == bsr_so)
		else $error("boundary register not on the serial path");

	loss_flag_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		rst_b && !mode_s2 |=> crystal_loss_flag == $past(nclk_s2))
		else $error("loss flag does not follow the clock monitor");

	sys_release_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		rst_b && !ext_c2 |=> sys_reset_b)
		else $error("system held in reset without external test");

endmodule : scan_instr_logic

// file: scan_master.sv
`timescale 1ns/1ps
// ************************************************************
// test controller model on the far side of the serial link
// ************************************************************
module scan_master
	import scan_pkg::*;
(
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// tck stands low between frames; lines start at their pull-up level
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// lines change just after the falling edge; tdo is taken at the shifting rising edge
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#16;
		q = tdo;
		tck = 1'b1;
		#16;
		tck = 1'b0;
	endtask : step

	// five ones always reach test-logic-reset, then park in run-test/idle
	task automatic to_reset();
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask : to_reset

	// idle to idle: capture, shift n bits lsb first, update
	task automatic scan(input logic ir, input int n, input logic [BSR_W-1:0] din,
		output logic [BSR_W-1:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir)
			step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int k = 0; k < n; k++)
		begin
			step(k == n - 1, din[k], q);
			dout[k] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask : scan

endmodule : scan_master

// file: scan_instr_logic_test.sv
`timescale 1ns/1ps
module scan_instr_logic_test
	import scan_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic no_clock_seen = 1'b0;
	logic ext_clock_mode = 1'b0;
	logic [BSR_W-1:0] core_out = '0, core_oe_b = '0, pin_in = '0, d = '0, q;
	logic [BSR_W-1:0] pad_out, pad_oe_b;
	logic tck, tms, tdi, tdo, tdo_oe_b, sys_reset_b;
	int num_errors = 0;
	int check_count = 0;

	always #4 clk = ~clk;

	scan_instr_logic uut (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe_b(tdo_oe_b), .no_clock_seen(no_clock_seen),
		.ext_clock_mode(ext_clock_mode), .sys_reset_b(sys_reset_b), .core_out(core_out),
		.core_oe_b(core_oe_b), .pin_in(pin_in), .pad_out(pad_out), .pad_oe_b(pad_oe_b));

	scan_master partner (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic check(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1)
		begin
			num_errors++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	function automatic logic [BSR_W-1:0] rnd();
		logic [159:0] r;
		r = {$urandom, $urandom, $urandom, $urandom, $urandom};
		return r[BSR_W-1:0];
	endfunction : rnd

	// codes with bit 1 or bit 2 set leave only the one-bit bypass stage on the link
	function automatic logic short_path(input logic [2:0] c);
		return c[1] || c[2];
	endfunction : short_path

	// system reset crosses into clk, so allow a bounded settling time
	task automatic wait_sys(input logic v);
		int n;
		n = 0;
		while (sys_reset_b !== v && n < 20)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check(sys_reset_b === v, "system reset level");
		if (sys_reset_b !== v)
			finish_test();
	endtask : wait_sys

	task automatic load(input logic [2:0] c, output logic [2:0] cap);
		logic [BSR_W-1:0] r;
		partner.scan(1'b1, IR_W, BSR_W'(c), r);
		cap = r[2:0];
	endtask : load

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		logic [2:0] cap;
		void'($urandom(32'hCAFF82B3));
		// reset held across tck pulses too, since the test side resets through a tck sync
		partner.to_reset();
		@(posedge clk);
		rst_b <= 1'b1;
		core_out <= rnd();
		core_oe_b <= rnd();
		partner.to_reset();
		wait_sys(1'b1);
		check(pad_out === core_out && pad_oe_b === core_oe_b, "pads after reset");
		d = rnd();
		partner.scan(1'b0, 2, d, q);
		check(q[1:0] === {d[0], 1'b0}, "bypass after reset");
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			ext_clock_mode <= k[1];
			no_clock_seen <= k[0];
			repeat (4) @(posedge clk);
			load(3'h7, cap);
			check(cap === {~k[1] & k[0], IR_CAPTURE_LOW}, "ir capture");
		end
		repeat (2)
			for (int c = 0; c < 8; c++)
			begin
				@(posedge clk);
				pin_in <= rnd();
				core_out <= rnd();
				core_oe_b <= rnd();
				load(3'(c), cap);
				check(cap === 3'h1, "ir capture external clock");
				d = rnd();
				if (short_path(3'(c)))
				begin
					partner.scan(1'b0, 2, d, q);
					check(q[1:0] === {d[0], 1'b0}, "one-bit path");
				end
				else
				begin
					partner.scan(1'b0, BSR_W, d, q);
					check(q === pin_in, "boundary capture");
				end
				wait_sys(c != 0);
				if (c == 0)
				begin
					check(pad_out[32] === d[32] && pad_oe_b[32] === 1'b0, "latch");
					check(pad_oe_b[27] === 1'b1, "input cell");
					check(pad_oe_b[45] === d[45] && pad_oe_b[52] === 1'b1, "open drain");
					check(pad_oe_b[75:70] === {6{~d[DATA_BUS_DRIVE_CTL]}}, "data");
					check(pad_out[70] === d[70], "data value");
					check(pad_oe_b[5] === ~d[83] && pad_oe_b[28] === d[29], "ctl");
				end
				else if (c == 4)
					check(pad_oe_b === '1 && pad_out === core_out, "outputs off");
				else
					check(pad_out === core_out && pad_oe_b === core_oe_b, "mission");
			end
		// a stuck external test must be left by five ones alone
		load(CODE_EXTEST, cap);
		wait_sys(1'b0);
		partner.to_reset();
		wait_sys(1'b1);
		check(pad_oe_b === core_oe_b && tdo_oe_b === 1'b1, "idle after reset");
		finish_test();
	end

endmodule : scan_instr_logic_test
